// [design/gtc_timer.sv]
// Purpose: Gated 16-bit timer/counter with prescaler, overflow interrupt and wake, behind AXI4-Lite.
// Assumes: aclk is the oscillator; pins and the comparator output are asynchronous to it.
// Notes:   Asynchronous counting is modelled by counting pin edges without instruction-cycle alignment.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/100ps

// Function
// - Sixteen-bit up-counter read as two bytes.
// - Byte writes load the live counter directly.
// - Source bit zero counts oscillator over four.
// - Source bit one counts pin or oscillator.
// - External counting synchronous or asynchronous to core.
// - Gate from comparator or gate pin.
// - Comparator output optionally synchronized to counter clock.
// - Overflow sets flag, interrupts, wakes if asynchronous.
// - Prescaler divides by one, two, four, eight.
// - Gated counting only while gate active, polarity selectable.
// - Sync-disable bit honoured only with external clock.
// - Low-power oscillator only in internal-oscillator-IO mode.
module gtc_timer
(
  input  wire logic                        aclk,                  // Oscillator clock.
  input  wire logic                        aresetn,               // Synchronous reset, active low.
  input  wire logic [gtc_pkg::ADDR_W-1:0]  s_axi_awaddr,          // Write address.
  input  wire logic                        s_axi_awvalid,         // Write address valid.
  output      logic                        s_axi_awready,         // Write address ready.
  input  wire logic [gtc_pkg::DATA_W-1:0]  s_axi_wdata,           // Write data.
  input  wire logic [3:0]                  s_axi_wstrb,           // Write byte strobes.
  input  wire logic                        s_axi_wvalid,          // Write data valid.
  output      logic                        s_axi_wready,          // Write data ready.
  output      logic [1:0]                  s_axi_bresp,           // Write response.
  output      logic                        s_axi_bvalid,          // Write response valid.
  input  wire logic                        s_axi_bready,          // Write response ready.
  input  wire logic [gtc_pkg::ADDR_W-1:0]  s_axi_araddr,          // Read address.
  input  wire logic                        s_axi_arvalid,         // Read address valid.
  output      logic                        s_axi_arready,         // Read address ready.
  output      logic [gtc_pkg::DATA_W-1:0]  s_axi_rdata,           // Read data.
  output      logic [1:0]                  s_axi_rresp,           // Read response.
  output      logic                        s_axi_rvalid,          // Read data valid.
  input  wire logic                        s_axi_rready,          // Read data ready.
  input  wire logic                        external_count_input,  // External count clock pin.
  input  wire logic                        low_power_oscillator,  // Low-power oscillator output.
  input  wire logic                        gate_input_pin,        // Gate pin.
  input  wire logic                        comparator_two_output, // Comparator output.
  input  wire logic                        internal_osc_io_mode,  // High while that oscillator mode is active.
  input  wire logic                        sleep_mode,            // High while the core sleeps.
  output      logic                        low_power_osc_on,      // Enables the low-power oscillator.
  output      logic                        wake,                  // One-cycle wake request.
  output      logic                        irq                    // Level interrupt.
);
  import gtc_pkg::*;

  // Returns the last prescaler phase for a prescale select code.
  function automatic logic [2:0] presc_last(input logic [1:0] sel);
    presc_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // Returns true when a byte address hits the word of a register index.
  function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] idx);
    hits = (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
  endfunction

  logic [15:0]       count;         // Live counter.
  logic [7:0]        timer_control; // Control register.
  logic [1:0]        gate_sel;      // Gate source and comparator sync bits.
  logic [7:0]        irq_status;    // Sticky flags.
  logic [7:0]        irq_mask;      // Interrupt mask.
  logic [2:0]        pre_cnt;       // Prescaler phase.
  logic [1:0]        inst_phase;    // Instruction clock divider.
  logic              pend;          // External edge waiting for the instruction cycle.
  logic              cmp_held;      // Comparator output sampled on the counter clock.
  logic              src_prev;      // Previous selected source level.
  logic              ext_s1;        // Pin synchroniser, first stage.
  logic              ext_s2;        // Pin synchroniser, second stage.
  logic              lp_s1;         // Oscillator synchroniser, first stage.
  logic              lp_s2;         // Oscillator synchroniser, second stage.
  logic              gpin_s1;       // Gate pin synchroniser, first stage.
  logic              gpin_s2;       // Gate pin synchroniser, second stage.
  logic              cmp_s1;        // Comparator synchroniser, first stage.
  logic              cmp_s2;        // Comparator synchroniser, second stage.
  logic              aw_held;       // Write address taken.
  logic              w_held;        // Write data taken.
  logic [ADDR_W-1:0] wr_addr_q;     // Held write address.
  logic [7:0]        wr_data_q;     // Held write data, low byte.
  logic              wr_strb_q;     // Held strobe of the low byte.

  logic              wr_do;         // Write executes this cycle.
  logic              wr_low;        // Write hits the low count byte.
  logic              wr_high;       // Write hits the high count byte.
  logic              wr_count;      // Write hits either count byte.
  logic              use_lp;        // Low-power oscillator drives the counter.
  logic              src_level;     // Selected external source level.
  logic              ext_edge;      // Rising edge of that source.
  logic              inst_tick;     // Last phase of each instruction cycle.
  logic              src_tick;      // Edge of the selected count clock.
  logic              gate_raw;      // Gate before polarity.
  logic              gate_active;   // Gate after polarity.
  logic              count_en;      // Counting allowed.
  logic              pre_tick;      // Prescaled count edge.
  logic              wrap;          // Counter wraps this cycle.
  logic              clk_src;       // Clock source select bit.
  logic              sync_dis;      // Sync disable bit.
  logic              next_pend;     // Next value of pend.

  assign clk_src  = timer_control[CTL_CLK_SRC];
  assign sync_dis = timer_control[CTL_SYNC_DIS];

  // Two flip-flops on every asynchronous input before any logic reads it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {ext_s1, ext_s2, lp_s1, lp_s2} <= 4'h0;
      {gpin_s1, gpin_s2, cmp_s1, cmp_s2} <= 4'h0;
    end
    else
    begin
      ext_s1  <= external_count_input;
      ext_s2  <= ext_s1;
      lp_s1   <= low_power_oscillator;
      lp_s2   <= lp_s1;
      gpin_s1 <= gate_input_pin;
      gpin_s2 <= gpin_s1;
      cmp_s1  <= comparator_two_output;
      cmp_s2  <= cmp_s1;
    end
  end

  // Oscillator is used only in the mode that frees its pins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      low_power_osc_on <= 1'b0;
    else
      low_power_osc_on <= timer_control[CTL_LP_OSC_EN] & internal_osc_io_mode;
  end

  // Source selection and edge detection; the pin counts on its rising edge.
  always_comb
  begin
    use_lp    = low_power_osc_on;
    src_level = use_lp ? lp_s2 : ext_s2;
    ext_edge  = src_level & ~src_prev;
    inst_tick = (inst_phase == INST_LAST);
    if (!clk_src)
      src_tick = inst_tick;
    else if (sync_dis)
      src_tick = ext_edge;
    else
      src_tick = inst_tick & (pend | ext_edge);
    next_pend = clk_src & ~sync_dis & (pend | ext_edge) & ~inst_tick;
  end

  // Instruction clock divider, edge history and pending synchronous edge.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inst_phase <= 2'h0;
      src_prev   <= 1'b0;
      pend       <= 1'b0;
    end
    else
    begin
      inst_phase <= inst_phase + 2'h1;
      src_prev   <= src_level;
      pend       <= next_pend;
    end
  end

  // Comparator output can be resampled on the counter clock to avoid mid-cycle gate changes.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cmp_held <= 1'b0;
    else if (src_tick)
      cmp_held <= cmp_s2;
  end

  // Gate source, polarity and count enable.
  always_comb
  begin
    if (gate_sel[GS_GATE_SRC])
      gate_raw = gpin_s2;
    else
      gate_raw = gate_sel[GS_CMP_SYNC] ? cmp_held : cmp_s2;
    gate_active = timer_control[CTL_GATE_POL] ? gate_raw : ~gate_raw;
    count_en    = timer_control[CTL_TIMER_ON] & (~timer_control[CTL_GATE_EN] | gate_active);
    pre_tick    = src_tick & count_en & (pre_cnt == presc_last(timer_control[CTL_PS_HI:CTL_PS_LO]));
    wrap        = pre_tick & (count == 16'hffff) & ~wr_count;
  end

  // Prescaler; a count write restarts it.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pre_cnt <= 3'h0;
    else if (wr_count)
      pre_cnt <= 3'h0;
    else if (pre_tick)
      pre_cnt <= 3'h0;
    else if (src_tick & count_en)
      pre_cnt <= pre_cnt + 3'h1;
  end

  // Counter; a byte write wins over a count edge in the same cycle.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count <= RST_COUNT;
    else if (wr_low)
      count[7:0] <= wr_data_q;
    else if (wr_high)
      count[15:8] <= wr_data_q;
    else if (pre_tick)
      count <= count + 16'h1;
  end

  // Wake pulse on overflow, only while counting an external clock asynchronously.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      wake <= 1'b0;
    else
      wake <= wrap & clk_src & sync_dis & sleep_mode;
  end

  // Write channel: address and data are taken in either order and held.
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_do   = aw_held & w_held & ~s_axi_bvalid;
  assign wr_low  = wr_do & wr_strb_q & hits(wr_addr_q, IDX_COUNT_LOW);
  assign wr_high = wr_do & wr_strb_q & hits(wr_addr_q, IDX_COUNT_HIGH);
  assign wr_count = wr_low | wr_high;

  // Holds the write address and data until both are present.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= 8'h00;
      wr_strb_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_held   <= 1'b1;
        wr_addr_q <= s_axi_awaddr;
      end
      else if (wr_do)
        aw_held <= 1'b0;
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_held    <= 1'b1;
        wr_data_q <= s_axi_wdata[7:0];
        wr_strb_q <= s_axi_wstrb[0];
      end
      else if (wr_do)
        w_held <= 1'b0;
    end
  end

  // Write response follows the executed write.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_do)
    begin
      s_axi_bvalid <= 1'b1;
      if (hits(wr_addr_q, IDX_COUNT_LOW) | hits(wr_addr_q, IDX_COUNT_HIGH) | hits(wr_addr_q, IDX_CONTROL)
          | hits(wr_addr_q, IDX_GATE_SEL) | hits(wr_addr_q, IDX_IRQ_STATUS) | hits(wr_addr_q, IDX_IRQ_MASK))
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control, gate select and mask registers.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_control <= RST_CONTROL;
      gate_sel      <= RST_GATE_SEL[1:0];
      irq_mask      <= 8'h00;
    end
    else if (wr_do & wr_strb_q)
    begin
      if (hits(wr_addr_q, IDX_CONTROL))
        timer_control <= wr_data_q;
      else if (hits(wr_addr_q, IDX_GATE_SEL))
        gate_sel <= wr_data_q[1:0] & GATE_SEL_MASK;
      else if (hits(wr_addr_q, IDX_IRQ_MASK))
        irq_mask <= wr_data_q;
    end
  end

  // Sticky status: overflow sets, a written one clears, and the set wins.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_status <= 8'h00;
    else
    begin
      if (wr_do & wr_strb_q & hits(wr_addr_q, IDX_IRQ_STATUS))
        irq_status[ST_OVERFLOW] <= (irq_status[ST_OVERFLOW] & ~wr_data_q[ST_OVERFLOW]) | wrap;
      else if (wrap)
        irq_status[ST_OVERFLOW] <= 1'b1;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // Read channel: one read at a time, data registered.
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid & s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (hits(s_axi_araddr, IDX_COUNT_LOW))
        s_axi_rdata[7:0] <= count[7:0];
      else if (hits(s_axi_araddr, IDX_COUNT_HIGH))
        s_axi_rdata[7:0] <= count[15:8];
      else if (hits(s_axi_araddr, IDX_CONTROL))
        s_axi_rdata[7:0] <= timer_control;
      else if (hits(s_axi_araddr, IDX_GATE_SEL))
        s_axi_rdata[1:0] <= gate_sel;
      else if (hits(s_axi_araddr, IDX_IRQ_STATUS))
        s_axi_rdata[7:0] <= irq_status;
      else if (hits(s_axi_araddr, IDX_IRQ_MASK))
        s_axi_rdata[7:0] <= irq_mask;
      else
        s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // A low byte write reaches the live counter at the next edge.
  property p_low_load;
    @(posedge aclk) disable iff (!aresetn)
    wr_low |=> count[7:0] == $past(wr_data_q);
  endproperty
  a_low_load: assert property (p_low_load) else $error("low byte write not loaded");

  // The instruction clock ticks once every four oscillator cycles.
  sequence s_quiet3;
    !inst_tick [*3];
  endsequence
  property p_inst_rate;
    @(posedge aclk) disable iff (!aresetn)
    inst_tick |=> s_quiet3 ##1 inst_tick;
  endproperty
  a_inst_rate: assert property (p_inst_rate) else $error("instruction tick spacing wrong");

  // With the internal clock the count clock is the instruction tick, whatever sync says.
  property p_internal_src;
    @(posedge aclk) disable iff (!aresetn)
    !clk_src |-> src_tick == inst_tick;
  endproperty
  a_internal_src: assert property (p_internal_src) else $error("internal clock path wrong");

  // Asynchronous external edges count without waiting for the instruction cycle.
  property p_async_edge;
    @(posedge aclk) disable iff (!aresetn)
    clk_src && sync_dis && ext_edge |-> src_tick;
  endproperty
  a_async_edge: assert property (p_async_edge) else $error("asynchronous edge missed");

  // A wrap clears the counter and raises the flag at the next edge.
  property p_wrap;
    @(posedge aclk) disable iff (!aresetn)
    wrap |=> count == 16'h0000 && irq_status[ST_OVERFLOW];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap did not clear count and set flag");

  // No wake outside asynchronous external counting.
  property p_wake;
    @(posedge aclk) disable iff (!aresetn)
    wrap && !(clk_src && sync_dis) |=> !wake;
  endproperty
  a_wake: assert property (p_wake) else $error("wake outside asynchronous mode");

  // An inactive gate freezes the counter.
  property p_gate_hold;
    @(posedge aclk) disable iff (!aresetn)
    timer_control[CTL_TIMER_ON] && timer_control[CTL_GATE_EN] && !gate_active && !wr_count |=> $stable(count);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("counted with gate inactive");

  // A prescaled edge falls only on the last phase for the selected division.
  property p_presc;
    @(posedge aclk) disable iff (!aresetn)
    pre_tick |-> pre_cnt == presc_last(timer_control[CTL_PS_HI:CTL_PS_LO]) && src_tick;
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler edge at wrong phase");

  // A synchronised comparator holds between counter clock edges.
  property p_cmp_hold;
    @(posedge aclk) disable iff (!aresetn)
    !src_tick |=> $stable(cmp_held);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("comparator sample moved between edges");

  // The oscillator enable follows the mode qualification one cycle later.
  property p_lp;
    @(posedge aclk) disable iff (!aresetn)
    !internal_osc_io_mode |=> !low_power_osc_on;
  endproperty
  a_lp: assert property (p_lp) else $error("oscillator on outside its mode");

  // The pin source drives the counter unless the oscillator is on.
  property p_src_sel;
    @(posedge aclk) disable iff (!aresetn)
    !low_power_osc_on |-> src_level == ext_s2;
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("external source selection wrong");

  // With the pin selected as gate, the gate follows the pin.
  property p_gate_src;
    @(posedge aclk) disable iff (!aresetn)
    gate_sel[GS_GATE_SRC] |-> gate_raw == gpin_s2;
  endproperty
  a_gate_src: assert property (p_gate_src) else $error("gate source selection wrong");

  // A stopped timer holds its count.
  property p_stopped;
    @(posedge aclk) disable iff (!aresetn)
    !timer_control[CTL_TIMER_ON] && !wr_count |=> $stable(count);
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped timer counted");

endmodule

// [design/gtc_pkg.sv]
// Purpose: Shared constants for the gated 16-bit timer/counter.
// Assumes: Registers sit one per aligned 32-bit word; byte address is four times the index.
// Notes:   Every offset, field position, timing count and register reset value except status and mask lives here.
package gtc_pkg;

  // Bus widths.
  localparam int ADDR_W = 8;   // Byte address width of the register bus.
  localparam int DATA_W = 32;  // Data width of the register bus.

  // Register indices as printed; byte address is four times the index.
  localparam logic [ADDR_W-1:0] IDX_COUNT_LOW  = 8'h0e;  // Low count byte.
  localparam logic [ADDR_W-1:0] IDX_COUNT_HIGH = 8'h0f;  // High count byte.
  localparam logic [ADDR_W-1:0] IDX_CONTROL    = 8'h10;  // Timer control.
  localparam logic [ADDR_W-1:0] IDX_GATE_SEL   = 8'h1a;  // Gate and comparator sync select.
  localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS = 8'h1c;  // Sticky event flags.
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK   = 8'h1d;  // Interrupt mask.

  // Timer control field positions.
  localparam int CTL_TIMER_ON  = 0;  // Timer on.
  localparam int CTL_CLK_SRC   = 1;  // Clock source select.
  localparam int CTL_SYNC_DIS  = 2;  // External clock sync disable.
  localparam int CTL_LP_OSC_EN = 3;  // Low-power oscillator enable.
  localparam int CTL_PS_LO     = 4;  // Prescale select, low bit.
  localparam int CTL_PS_HI     = 5;  // Prescale select, high bit.
  localparam int CTL_GATE_EN   = 6;  // Gate enable.
  localparam int CTL_GATE_POL  = 7;  // Gate polarity.

  // Gate select field positions.
  localparam int GS_CMP_SYNC = 0;  // Comparator sync.
  localparam int GS_GATE_SRC = 1;  // Gate source select, 1 picks the pin.

  // Status and mask bit positions.
  localparam int ST_OVERFLOW = 0;  // Overflow flag.

  // Reset values.
  localparam logic [7:0]  RST_CONTROL  = 8'h00;   // Timer control after reset.
  localparam logic [7:0]  RST_GATE_SEL = 8'h02;   // Gate select after reset.
  localparam logic [15:0] RST_COUNT    = 16'h0000; // Counter after reset.
  localparam logic [1:0]  GATE_SEL_MASK = 2'h3;   // Writable gate select bits.

  // Timing: the oscillator is aclk; the instruction clock is aclk divided by four.
  localparam int          CLK_PERIOD_NS = 5;  // Period of aclk in ns.
  localparam int          INST_DIV      = 4;  // Oscillator cycles per instruction cycle.
  localparam logic [1:0]  INST_LAST     = 2'(INST_DIV - 1); // Last phase of the divider.

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;  // Access done.
  localparam logic [1:0] RESP_SLVERR = 2'h2;  // Unmapped address.

endpackage

// [tb/gtc_pins.sv]
// Purpose: Pin-side model of the count clock, gate pin and comparator.
// Assumes: The count pin idles low and moves only on request.
// Notes: Each level is held 8 clocks so the pin synchronizers settle.
`timescale 1ns/100ps
module gtc_pins
(
  input  wire logic aclk,                         // Paces the waveforms.
  output logic      external_count_input = 1'b0,  // Count clock pin.
  output logic      gate_input_pin = 1'b0,        // Gate pin level.
  output logic      comparator_two_output = 1'b0  // Comparator level.
);
  task automatic pulse(input int n, input logic g, input logic c);
    {gate_input_pin, comparator_two_output} <= {g, c};
    repeat (2 * n)
    begin
      repeat (8) @(posedge aclk);
      external_count_input <= ~external_count_input;
    end
    repeat (8) @(posedge aclk);
  endtask
endmodule

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the gated timer/counter.
// Assumes: Bus tasks sample at the falling edge and drive just after the rising edge.
// Notes: The low-power oscillator input is held low, so that clock path is not exercised.
`timescale 1ns/100ps
module tb_top;
  import gtc_pkg::*;
  logic        aclk = '0, aresetn = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, woke = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, internal_osc_io_mode = '0, sleep_mode = '0, irq, wake;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, low_power_osc_on;
  logic        external_count_input, gate_input_pin, comparator_two_output; // Pin levels.
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;  // Byte addresses.
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, ld;     // Data and last read data.
  logic [1:0]  s_axi_bresp, s_axi_rresp, lr;          // Responses and last read or write response.
  logic [3:0]  v;                                     // Readies and answer seen at the falling edge.
  int          bad_count = 0, n_tests = 0, k;         // Mismatches, comparisons, wait count.
  gtc_timer gtc_timer_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'h1), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_count_input,
    .low_power_oscillator(1'b0), .gate_input_pin, .comparator_two_output, .internal_osc_io_mode, .sleep_mode,
    .low_power_osc_on, .wake, .irq);
  gtc_pins gtc_pins_inst (.aclk, .external_count_input, .gate_input_pin, .comparator_two_output);
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) if (wake === 1'b1) woke <= 1'b1;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
      $display("mismatch %s expected %h seen %h", nm, e, s);
    bad_count += int'(s !== e);
  endtask
  // One write (w high) or read; a read must match d within t counts.
  task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d, input string nm = "", input int t = 0);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {i << 2, i << 2, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (k = 0; k < 50; k++)
    begin
      @(negedge aclk);
      v = {s_axi_awready, s_axi_wready, s_axi_arready, w ? s_axi_bvalid : s_axi_rvalid};
      {ld, lr} = {s_axi_rdata, w ? s_axi_bresp : s_axi_rresp};
      @(posedge aclk);
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} & ~v[3:1];
      if (v[0] === 1'b1) break;
    end
    if (k == 50) finish_test(1'b1);
    if (!w) chk(nm, (ld + t - d <= 2 * t) ? d : ld, d);
  endtask
  task automatic finish_test(input logic t);
    bad_count += t;
    $display("%0d mismatches in %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_regs();
    bus(0, IDX_CONTROL, 32'(RST_CONTROL), "control");
    bus(0, IDX_GATE_SEL, 32'(RST_GATE_SEL), "gate_sel");
    bus(0, 8'h00, '0, "unmapped");
    chk("resp", 32'(lr), 32'(RESP_SLVERR));
    bus(1, 8'h00, 32'h05);
    chk("wresp_bad", 32'(lr), 32'(RESP_SLVERR));
    bus(1, IDX_GATE_SEL, 32'hff);
    chk("wresp_ok", 32'(lr), 32'(RESP_OKAY));
    bus(0, IDX_GATE_SEL, 32'(GATE_SEL_MASK), "gate_sel_rw");
    bus(1, IDX_CONTROL, 32'h08);
    internal_osc_io_mode <= 1'b1;
    repeat (3) @(negedge aclk);
    chk("lpo_on", 32'(low_power_osc_on), 32'h1);
    $display("test registers done");
  endtask
  task automatic t_ps();
    for (int p = 0; p < 4; p++)
    begin
      bus(1, IDX_COUNT_LOW, '0);
      bus(1, IDX_CONTROL, 32'h01 | (p << 4));
      repeat (256) @(posedge aclk);
      bus(1, IDX_CONTROL, '0);
      bus(0, IDX_COUNT_LOW, 32'(64 >> p), "prescaled", 1);
    end
    $display("test prescale done");
  endtask
  task automatic t_pins();
    bus(1, IDX_COUNT_LOW, '0);
    bus(1, IDX_CONTROL, 32'hc3);
    gtc_pins_inst.pulse(3, 1'b0, 1'b1);
    bus(0, IDX_COUNT_LOW, '0, "gate_shut");
    gtc_pins_inst.pulse(2, 1'b1, 1'b0);
    bus(0, IDX_COUNT_LOW, 32'h02, "gate_open");
    bus(1, IDX_GATE_SEL, '0);
    bus(1, IDX_CONTROL, 32'h47);
    gtc_pins_inst.pulse(3, 1'b1, 1'b0);
    bus(0, IDX_COUNT_LOW, 32'h05, "cmp_open");
    bus(1, IDX_GATE_SEL, 32'h01);
    gtc_pins_inst.pulse(2, 1'b1, 1'b0);
    bus(0, IDX_COUNT_LOW, 32'h07, "cmp_sync_open");
    gtc_pins_inst.pulse(2, 1'b1, 1'b1);
    bus(0, IDX_COUNT_LOW, 32'h08, "cmp_sync_late");
    $display("test pins done");
  endtask
  task automatic t_ovf();
    bus(1, IDX_COUNT_LOW, 32'hff);
    bus(1, IDX_COUNT_HIGH, 32'hff);
    bus(1, IDX_IRQ_MASK, 32'h1);
    bus(1, IDX_CONTROL, 32'h07);
    sleep_mode <= 1'b1;
    gtc_pins_inst.pulse(1, 1'b0, 1'b0);
    bus(0, IDX_COUNT_HIGH, '0, "wrapped");
    bus(0, IDX_IRQ_STATUS, 32'h1, "flag");
    chk("irq", 32'(irq), 32'h1);
    chk("wake", 32'(woke), 32'h1);
    bus(1, IDX_IRQ_MASK, '0);
    chk("irq_masked", 32'(irq), '0);
    bus(1, IDX_IRQ_STATUS, 32'h1);
    bus(0, IDX_IRQ_STATUS, '0, "flag_clear");
    $display("test overflow done");
  endtask
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_ps();
    t_pins();
    t_ovf();
    finish_test(1'b0);
  end
endmodule
